// ---- src/ifc_pkg.sv ----
// package for the intermediate-frequency counter gate block
// assumes a 100 MHz system clock and a 32-bit APB master
package ifc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SYS_REF_HZ = 4_500_000;
    localparam int unsigned TICK_HZ = 1_000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W = 17;
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [11:0] ADDR_COUNT = 12'h00C;
    localparam logic [11:0] ADDR_SYS = 12'h010;
    localparam int unsigned MODE_SEL_LSB = 0;
    localparam int unsigned MODE_GATE_LSB = 2;
    localparam int unsigned CTRL_CLR_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned SYS_HALT_BIT = 0;
    localparam int unsigned SYS_CKSTOP_BIT = 1;
    localparam int unsigned SYS_CERST_BIT = 2;
    localparam int unsigned SYS_TONE_BIT = 3;
    localparam logic [1:0] SEL_PORT = 2'h0;
    localparam logic [1:0] SEL_FM = 2'h1;
    localparam logic [1:0] SEL_AM = 2'h2;
    localparam logic [1:0] GATE_1MS = 2'h0;
    localparam logic [1:0] GATE_4MS = 2'h1;
    localparam logic [1:0] GATE_8MS = 2'h2;
    localparam logic [1:0] GATE_OPEN = 2'h3;
    localparam logic [3:0] MS_1 = 4'h1;
    localparam logic [3:0] MS_4 = 4'h4;
    localparam logic [3:0] MS_8 = 4'h8;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] UNDEF_READ = 32'hDEAD_0000;
    localparam int unsigned TONE_HALF = 50_000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_OPEN = 3'b100
    } ifc_state_type;
    typedef struct packed {
        logic [1:0] gate_time;
        logic [1:0] input_select;
    } ifc_mode_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ifc_apb_req_type;
endpackage

// ---- src/ifc_counter.sv ----
// frequency counter with timed gate, APB registers and shared tone output
// assumes APB inputs and pins are synchronous to CLK_I
// Behaviour
// - status register shows whether a timed gate is waiting for its tick or open
// - gate timing derived by dividing the system clock
// - count increments on each rising edge of selected input while open, except an edge on the closing tick
// - input already high at gate open counts one extra
// - power-on reset and clock stop return pins to port mode
// - chip-enable reset keeps pin selection
// - halt keeps pin configuration
// - halt before the gate opens means the gate never opens
// - no interrupt when gate never opened
// - tone active: nonzero select freezes tone pin, zero restarts tone
// - tone active: count reads undefined, writes ignored, tone unaffected
// - starting tone stops counting; fresh start needed afterwards
// - gate opens at next 1 kHz tick, lasts 1/4/8 ms, flag set on start
// - clear flag zeroes count; count wraps at maximum
// - fm input divided by two, am input undivided
// - start and clear are write-only, read as zero
`timescale 1ns/1ps
module ifc_counter #(
    parameter int unsigned TICK_CYCLES_P = ifc_pkg::TICK_CYCLES,
    parameter int unsigned TONE_HALF_P = ifc_pkg::TONE_HALF
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire ifc_pkg::ifc_apb_req_type APB_REQ_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic FM_IF_INPUT_I,
    input wire logic AM_IF_INPUT_I,
    output logic FM_PIN_COUNTER_O,
    output logic AM_PIN_COUNTER_O,
    output logic TONE_OUTPUT_O,
    output logic GATE_IRQ_O
);
    import ifc_pkg::*;

    initial begin
        if (TICK_CYCLES_P < 2 || TICK_CYCLES_P >= (1 << TICK_W)) begin
            $error("tick divider out of range");
        end
        if (TONE_HALF_P < 1 || TONE_HALF_P >= (1 << TICK_W)) begin
            $error("tone divider out of range");
        end
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);
    localparam logic [TICK_W-1:0] TONE_LAST = TICK_W'(TONE_HALF_P - 1);

    logic acc, wr, rd;
    logic [11:0] addr;
    logic [31:0] wdata;
    ifc_mode_type mode, next_mode;
    ifc_state_type state, next_state;
    logic [15:0] count, next_count;
    logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
    logic [TICK_W-1:0] tone_cnt, next_tone_cnt;
    logic [3:0] ms_cnt, next_ms_cnt;
    logic [3:0] ms_len;
    logic tick, fm_div, next_fm_div, sel_prev, next_sel_prev, sel_sig;
    logic halt, next_halt, tone_on, next_tone_on, tone, next_tone;
    logic irq, next_irq, gate_open_flag, gate_live;
    logic blocked, next_blocked;
    logic [31:0] next_prdata;

    assign acc = APB_REQ_I.psel && APB_REQ_I.penable;
    assign wr = acc && APB_REQ_I.pwrite;
    assign rd = APB_REQ_I.psel && !APB_REQ_I.penable && !APB_REQ_I.pwrite;
    assign addr = APB_REQ_I.paddr;
    assign wdata = APB_REQ_I.pwdata;
    assign PREADY_O = 1'b1;
    assign tick = (tick_cnt == TICK_LAST);
    assign gate_open_flag = (state != ST_IDLE);
    assign gate_live = (state == ST_OPEN) ||
        (mode.gate_time == GATE_OPEN && state == ST_IDLE && !tone_on);
    assign FM_PIN_COUNTER_O = (mode.input_select == SEL_FM);
    assign AM_PIN_COUNTER_O = (mode.input_select == SEL_AM);
    assign TONE_OUTPUT_O = tone;
    assign GATE_IRQ_O = irq;

    always_comb begin
        case (mode.gate_time)
            GATE_1MS: ms_len = MS_1;
            GATE_4MS: ms_len = MS_4;
            GATE_8MS: ms_len = MS_8;
            default: ms_len = MS_1;
        endcase
        case (mode.input_select)
            SEL_FM: sel_sig = fm_div;
            SEL_AM: sel_sig = AM_IF_INPUT_I;
            default: sel_sig = 1'b0;
        endcase
    end

    always_comb begin
        next_mode = mode;
        next_state = state;
        next_count = count;
        next_ms_cnt = ms_cnt;
        next_halt = halt;
        next_tone_on = tone_on;
        next_tone = tone;
        next_tone_cnt = tone_cnt;
        next_irq = 1'b0;
        next_blocked = blocked;
        next_prdata = PRDATA_O;
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
        next_fm_div = FM_IF_INPUT_I ? ~fm_div : fm_div;
        next_sel_prev = sel_sig;
        if (mode.input_select != SEL_FM) begin
            next_fm_div = 1'b0;
        end
        if (gate_live && !tone_on) begin
            if (state == ST_OPEN && ms_cnt == ms_len - 1'b1 && tick) begin
            end else if (sel_sig && !sel_prev) begin
                next_count = count + 1'b1;
            end
        end
        case (state)
            ST_IDLE: begin
            end
            ST_WAIT: begin
                if (halt) begin
                    next_blocked = 1'b1;
                end else if (tick && !blocked) begin
                    next_state = ST_OPEN;
                    next_ms_cnt = '0;
                    if (sel_sig) begin
                        next_count = count + 1'b1;
                    end
                end
            end
            ST_OPEN: begin
                if (tick) begin
                    next_ms_cnt = ms_cnt + 1'b1;
                    if (ms_cnt == ms_len - 1'b1) begin
                        next_state = ST_IDLE;
                        next_irq = 1'b1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (tone_on && mode.input_select == SEL_PORT) begin
            next_tone_cnt = tone_cnt + 1'b1;
            if (tone_cnt == TONE_LAST) begin
                next_tone_cnt = '0;
                next_tone = ~tone;
            end
        end
        if (wr) begin
            case (addr)
                ADDR_MODE: begin
                    next_mode = ifc_mode_type'(wdata[3:0]);
                end
                ADDR_CTRL: begin
                    if (wdata[CTRL_CLR_BIT] && !tone_on) begin
                        next_count = COUNT_RESET;
                    end
                    if (wdata[CTRL_START_BIT] && !tone_on) begin
                        next_state = ST_WAIT;
                        next_blocked = 1'b0;
                    end
                end
                ADDR_SYS: begin
                    next_halt = wdata[SYS_HALT_BIT];
                    if (wdata[SYS_CKSTOP_BIT]) begin
                        next_mode.input_select = SEL_PORT;
                    end
                    if (wdata[SYS_CERST_BIT]) begin
                        next_state = ST_IDLE;
                        next_blocked = 1'b0;
                    end
                    if (wdata[SYS_TONE_BIT] && !tone_on) begin
                        next_state = ST_IDLE;
                    end
                    next_tone_on = wdata[SYS_TONE_BIT];
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                ADDR_MODE: next_prdata = {28'h000_0000, mode};
                ADDR_CTRL: next_prdata = 32'h0000_0000;
                ADDR_STAT: next_prdata = {31'h0000_0000,
                    gate_open_flag};
                ADDR_COUNT: next_prdata = tone_on ? UNDEF_READ :
                    {16'h0000, count};
                ADDR_SYS: next_prdata = {28'h000_0000, tone_on, 2'b00,
                    halt};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        PSLVERR_O = acc && !(addr == ADDR_MODE || addr == ADDR_CTRL ||
            addr == ADDR_STAT || addr == ADDR_COUNT || addr == ADDR_SYS);
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode <= ifc_mode_type'(MODE_RESET);
            state <= ST_IDLE;
            count <= COUNT_RESET;
            ms_cnt <= '0;
            tick_cnt <= '0;
            tone_cnt <= '0;
            fm_div <= 1'b0;
            sel_prev <= 1'b0;
            halt <= 1'b0;
            tone_on <= 1'b0;
            tone <= 1'b0;
            irq <= 1'b0;
            blocked <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            mode <= next_mode;
            state <= next_state;
            count <= next_count;
            ms_cnt <= next_ms_cnt;
            tick_cnt <= next_tick_cnt;
            tone_cnt <= next_tone_cnt;
            fm_div <= next_fm_div;
            sel_prev <= next_sel_prev;
            halt <= next_halt;
            tone_on <= next_tone_on;
            tone <= next_tone;
            irq <= next_irq;
            blocked <= next_blocked;
            PRDATA_O <= next_prdata;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    a_irq_on_close: assert property (
        (state == ST_OPEN && tick && ms_cnt == ms_len - 1'b1 && !wr)
        |=> GATE_IRQ_O && state == ST_IDLE)
        else $error("no irq at gate close");
    a_irq_needs_open: assert property (
        GATE_IRQ_O |-> $past(state) == ST_OPEN)
        else $error("irq without open gate");
    a_halt_blocks: assert property (
        (state == ST_WAIT && halt && !wr) |=> state != ST_OPEN)
        else $error("gate opened during halt");
    a_flag_on_start: assert property (
        (wr && addr == ADDR_CTRL && wdata[CTRL_START_BIT] && !tone_on)
        |=> gate_open_flag)
        else $error("flag not set on start");
    a_clear_count: assert property (
        (wr && addr == ADDR_CTRL && wdata[CTRL_CLR_BIT] && !tone_on)
        |=> count == COUNT_RESET)
        else $error("count not cleared");
    a_ctrl_reads_zero: assert property (
        (rd && addr == ADDR_CTRL) |=> PRDATA_O == 32'h0000_0000)
        else $error("control register readable");
    a_tone_freeze: assert property (
        (mode.input_select != SEL_PORT && !wr) |=> $stable(tone))
        else $error("tone moved while frozen");
    a_tone_no_count: assert property (
        (tone_on && !wr) |=> $stable(count))
        else $error("count changed under tone");
    a_ckstop_port: assert property (
        (wr && addr == ADDR_SYS && wdata[SYS_CKSTOP_BIT])
        |=> mode.input_select == SEL_PORT)
        else $error("clock stop kept pin select");
    a_tone_stops: assert property (
        (wr && addr == ADDR_SYS && wdata[SYS_TONE_BIT])
        |=> state == ST_IDLE)
        else $error("tone start left counter running");
    a_wait_opens: assert property (
        (state == ST_WAIT && tick && !halt && !blocked && !wr)
        |=> state == ST_OPEN)
        else $error("gate did not open on tick");
    a_blocked_holds: assert property (
        (state == ST_WAIT && blocked && !wr) |=> state != ST_OPEN)
        else $error("gate opened after halt in wait");
    a_idle_count_hold: assert property (
        (state == ST_IDLE && mode.gate_time != GATE_OPEN && !wr)
        |=> $stable(count))
        else $error("count moved with gate closed");
    a_fm_div_off: assert property (
        (mode.input_select != SEL_FM) |=> !fm_div)
        else $error("fm divider ran while unselected");

    c_gate_close: cover property (GATE_IRQ_O);
    c_open_state: cover property (state == ST_OPEN && count != 16'h0000);
    c_tone_toggle: cover property (tone_on && $changed(tone));
    c_halt_wait: cover property (state == ST_WAIT && halt);
    c_open_mode: cover property (gate_live && state == ST_IDLE);
endmodule

// ---- verification/ifc_if_source.sv ----
// if signal source driving both counter input pins
// assumes CLK_I runs free; one-cycle pulse per input edge
`timescale 1ns/1ps
module ifc_if_source (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic [3:0] period_i,
    output logic fm_o,
    output logic am_o
);
    logic [3:0] phase;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase <= 4'h0;
        end else if (phase + 4'h1 >= period_i) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end
    assign fm_o = en_i && phase == 4'h0;
    assign am_o = en_i && phase == 4'h0;
endmodule

// ---- verification/if_frequency_counter_gate_bench.sv ----
// self-checking bench for ifc_counter against a pulse counting model
// assumes ifc_if_source on the pins; apb waits for pready
`timescale 1ns/1ps
module if_frequency_counter_gate_bench;
    import ifc_pkg::*;
    localparam int TC = 10;
    logic clk;
    logic rst_n;
    ifc_apb_req_type req;
    logic [31:0] prdata;
    logic pready, pslverr, fm, am, fm_pin, am_pin, tone, irq;
    logic [3:0] period;
    logic err;
    logic [31:0] rd;
    logic [1:0] gates [3] = '{GATE_1MS, GATE_4MS, GATE_8MS};
    int mss [3] = '{MS_1, MS_4, MS_8};
    int fail_count, checks, cyc, irqs, i, c, i0;
    ifc_counter #(.TICK_CYCLES_P(TC), .TONE_HALF_P(4)) uut (
        .CLK_I(clk), .ARST_N_I(rst_n), .APB_REQ_I(req), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FM_IF_INPUT_I(fm),
        .AM_IF_INPUT_I(am), .FM_PIN_COUNTER_O(fm_pin),
        .AM_PIN_COUNTER_O(am_pin), .TONE_OUTPUT_O(tone), .GATE_IRQ_O(irq));
    ifc_if_source src (.clk_i(clk), .arst_n_i(rst_n), .en_i(1'b1),
        .period_i(period), .fm_o(fm), .am_o(am));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err = pslverr;
        rd = prdata;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic tone_edges(output int n);
        logic last;
        n = 0;
        last = tone;
        repeat (24) begin
            @(posedge clk);
            if (tone !== last) n++;
            last = tone;
        end
    endtask
    task automatic measure(input logic [1:0] s, input int gi,
                           input logic [3:0] p);
        int pulses, lo, hi;
        period <= p;
        apb(1'b1, ADDR_MODE, 32'({gates[gi], s}));
        repeat (20) @(posedge clk);
        pulses = mss[gi] * TC / p;
        lo = s == SEL_FM ? pulses / 2 : pulses;
        hi = s == SEL_FM ? (pulses + 1) / 2 + 1 : pulses + 1;
        i0 = irqs;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        check(rd[0] === 1'b1, "gate flag not set after start");
        for (int k = 0; k < 100 && rd[0] !== 1'b0; k++) begin
            apb(1'b0, ADDR_STAT, 32'h0000_0000);
        end
        check(rd[0] === 1'b0, "gate never closed");
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        check(rd[15:0] >= lo && rd[15:0] <= hi, "count out of range");
        check(irqs == i0 + 1, "gate close request missing");
    endtask
    initial begin
        req = '0;
        rst_n = 1'b0;
        period = 4'h5;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        irqs = 0;
        void'($urandom(32'h2f7f_6c5b));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(fm_pin === 1'b0 && am_pin === 1'b0, "pins not in port mode");
        apb(1'b0, ADDR_MODE, 32'h0000_0000);
        check(rd[3:0] === MODE_RESET, "mode reset value");
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        check(rd[15:0] === COUNT_RESET, "count reset value");
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        check(rd === 32'h0000_0000, "control reads back");
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check(err === 1'b1 && rd === 32'h0000_0000, "unmapped access");
        for (i = 0; i < 6; i++) begin
            measure(i % 2 ? SEL_AM : SEL_FM, i / 2,
                    $urandom_range(0, 1) ? 4'h2 : 4'h5);
        end
        check(am_pin === 1'b1 && fm_pin === 1'b0, "am pin not selected");
        apb(1'b1, ADDR_SYS, 32'h0000_0004);
        check(am_pin === 1'b1, "chip enable reset lost pin mode");
        i0 = irqs;
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        repeat (2 * TC) @(posedge clk);
        apb(1'b1, ADDR_SYS, 32'h0000_0001);
        check(am_pin === 1'b1, "halt lost pin mode");
        repeat (9 * TC) @(posedge clk);
        check(irqs == i0 + 1, "open gate lost to halt");
        i0 = irqs;
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        repeat (120) @(posedge clk);
        check(irqs == i0, "gate opened during halt");
        apb(1'b1, ADDR_SYS, 32'h0000_0000);
        repeat (120) @(posedge clk);
        check(irqs == i0, "gate opened after halt release");
        apb(1'b1, ADDR_SYS, 32'h0000_0004);
        apb(1'b1, ADDR_SYS, 32'h0000_0002);
        check(fm_pin === 1'b0 && am_pin === 1'b0, "clock stop pins");
        period <= 4'h5;
        apb(1'b1, ADDR_MODE, 32'({GATE_OPEN, SEL_AM}));
        repeat (20) @(posedge clk);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (50) @(posedge clk);
        apb(1'b1, ADDR_MODE, 32'({GATE_1MS, SEL_AM}));
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        c = (50 + 3) / 5;
        check(rd[15:0] >= c && rd[15:0] <= c + 1, "open gate count");
        apb(1'b1, ADDR_MODE, 32'h0000_0000);
        apb(1'b1, ADDR_SYS, 32'h0000_0008);
        tone_edges(c);
        check(c >= 4, "tone not running");
        apb(1'b1, ADDR_COUNT, 32'h0000_1234);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        check(rd === UNDEF_READ, "count read during tone");
        tone_edges(c);
        check(c >= 4, "tone disturbed by count access");
        apb(1'b1, ADDR_MODE, 32'(SEL_FM));
        tone_edges(c);
        check(c == 0, "tone not frozen");
        apb(1'b1, ADDR_MODE, 32'(SEL_PORT));
        tone_edges(c);
        check(c >= 4, "tone not restarted");
        apb(1'b1, ADDR_SYS, 32'h0000_0000);
        apb(1'b1, ADDR_MODE, 32'({GATE_8MS, SEL_AM}));
        repeat (20) @(posedge clk);
        i0 = irqs;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        repeat (15) @(posedge clk);
        apb(1'b1, ADDR_SYS, 32'h0000_0008);
        repeat (120) @(posedge clk);
        check(irqs == i0, "count survived tone start");
        apb(1'b1, ADDR_SYS, 32'h0000_0000);
        measure(SEL_AM, 1, 4'h5);
        conclude();
    end
endmodule
